// ==== common/flash_seq_pkg.sv ====
// constants for the longword flash command sequencer
package flash_seq_pkg;
    localparam int ADDR_W = 18;
    localparam int REGION_W = 5;
    localparam int INFO_ADDR_W = 8;
    localparam int WORD_LSB = 2;
    localparam logic [7:0] CMD_PROGRAM_LONGWORD = 8'h06;
    localparam logic [7:0] CMD_PROGRAM_SECTION = 8'h0B;
    localparam logic [7:0] CMD_SWAP = 8'h46;
    localparam logic [7:0] CMD_PROGRAM_ONCE = 8'h43;
    localparam logic [7:0] CMD_ERASE_SECTOR = 8'h09;
    localparam logic [INFO_ADDR_W-1:0] ONCE_FIRST = 8'hC0;
    localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
    localparam int PROG_CYCLES = 4;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUSY,
        ST_DONE
    } seq_state_t;
endpackage

// ==== core/flash_busy_timer.sv ====
// down counter timing one array operation
`timescale 1ns/10ps
module flash_busy_timer #(
    parameter int CYCLES = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // control
    input wire logic start,
    output logic expired
);
    localparam int CNT_W = $clog2(CYCLES + 1);
    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;
    always_comb begin
        nxt_count = count_ff;
        if (start) begin
            nxt_count = CNT_W'(CYCLES);
        end else if (count_ff != '0) begin
            nxt_count = count_ff - CNT_W'(1);
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end
    assign expired = (count_ff == CNT_W'(1));
endmodule

// ==== core/flash_longword_sequencer.sv ====
// longword program sequencer for a single-block flash array
`timescale 1ns/10ps
module flash_longword_sequencer #(
    parameter int PROG_CYCLES = flash_seq_pkg::PROG_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // command launch
    input wire logic launch,
    input wire logic [7:0] flash_command_code,
    input wire logic [flash_seq_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [31:0] cmd_data,
    input wire logic [31:0] protect_mask,
    input wire logic fetch_active,
    input wire logic clear_errors,
    // status
    output logic busy,
    output logic done,
    output logic access_error,
    output logic protect_error,
    // array write port
    output logic array_we,
    output logic array_info,
    output logic [flash_seq_pkg::ADDR_W-1:0] array_addr,
    output logic [31:0] array_wdata
);
    flash_seq_pkg::seq_state_t state_ff, nxt_state;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic acc_ff, nxt_acc;
    logic prot_ff, nxt_prot;
    logic we_ff, nxt_we;
    logic info_ff, nxt_info;
    logic [flash_seq_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic timer_start;
    logic timer_expired;
    logic [flash_seq_pkg::REGION_W-1:0] region;
    logic [flash_seq_pkg::INFO_ADDR_W-1:0] info_off;
    // decoded command and refusal causes
    logic is_prog, is_once, is_erase, bad_code;
    logic resv_off, in_prot;
    logic take, accept;
    logic set_acc, set_prot;
    logic end_write;
    logic [flash_seq_pkg::ADDR_W-1:0] word_addr;
    logic [flash_seq_pkg::ADDR_W-1:0] info_addr;

    // busy interval timer
    flash_busy_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(timer_start),
        .expired(timer_expired)
    );

    // top five address bits pick one of 32 regions
    assign region = cmd_addr[flash_seq_pkg::ADDR_W-1 -:
        flash_seq_pkg::REGION_W];
    assign info_off = cmd_addr[flash_seq_pkg::INFO_ADDR_W-1:0];

    // command decode; a launch is taken only in idle
    always_comb begin
        is_prog = 1'b0;
        is_once = 1'b0;
        is_erase = 1'b0;
        bad_code = 1'b0;
        unique case (flash_command_code)
            flash_seq_pkg::CMD_PROGRAM_LONGWORD: begin
                is_prog = 1'b1;
            end
            flash_seq_pkg::CMD_PROGRAM_ONCE: begin
                is_once = 1'b1;
            end
            flash_seq_pkg::CMD_ERASE_SECTOR: begin
                is_erase = 1'b1;
            end
            // 0x0B, 0x46, emulation RAM and the rest
            default: begin
                bad_code = 1'b1;
            end
        endcase
        resv_off = is_once &&
            (info_off < flash_seq_pkg::ONCE_FIRST);
        in_prot = (is_prog || is_erase) && protect_mask[region];
        take = launch && (state_ff == flash_seq_pkg::ST_IDLE);
        // a launch while code is fetched is refused with an access error
        set_acc = take && (fetch_active || bad_code || resv_off);
        set_prot = take && !fetch_active && in_prot;
        accept = take && !set_acc && !set_prot;
        end_write = (state_ff == flash_seq_pkg::ST_BUSY) && timer_expired;
        word_addr = cmd_addr;
        word_addr[flash_seq_pkg::WORD_LSB-1:0] = '0;
        info_addr = '0;
        info_addr[flash_seq_pkg::INFO_ADDR_W-1:0] = info_off;
        info_addr[flash_seq_pkg::WORD_LSB-1:0] = '0;
    end

    // sticky error flags; a new error in the clearing cycle wins
    always_comb begin
        nxt_acc = acc_ff;
        nxt_prot = prot_ff;
        if (clear_errors) begin
            nxt_acc = 1'b0;
            nxt_prot = 1'b0;
        end
        if (set_acc) begin
            nxt_acc = 1'b1;
        end
        if (set_prot) begin
            nxt_prot = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= 1'b0;
            prot_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            prot_ff <= nxt_prot;
        end
    end

    // sequence state, busy level and done pulse
    always_comb begin
        nxt_state = state_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        timer_start = 1'b0;
        unique case (state_ff)
            flash_seq_pkg::ST_IDLE: begin
                if (accept) begin
                    nxt_busy = 1'b1;
                    timer_start = 1'b1;
                    nxt_state = flash_seq_pkg::ST_BUSY;
                end
            end
            flash_seq_pkg::ST_BUSY: begin
                if (timer_expired) begin
                    nxt_state = flash_seq_pkg::ST_DONE;
                end
            end
            flash_seq_pkg::ST_DONE: begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
                nxt_state = flash_seq_pkg::ST_IDLE;
            end
            default: begin
                nxt_state = flash_seq_pkg::ST_IDLE;
                nxt_busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= flash_seq_pkg::ST_IDLE;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
        end
    end

    // write port: loaded on accept, strobed once the timer runs out
    always_comb begin
        nxt_we = end_write;
        nxt_info = info_ff;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        if (accept) begin
            // one aligned 32-bit word per command
            nxt_info = is_once;
            nxt_addr = word_addr;
            nxt_wdata = cmd_data;
            if (is_once) begin
                nxt_addr = info_addr;
            end
            if (is_erase) begin
                nxt_wdata = flash_seq_pkg::ERASED_WORD;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            we_ff <= 1'b0;
            info_ff <= 1'b0;
            addr_ff <= '0;
            wdata_ff <= '0;
        end else begin
            we_ff <= nxt_we;
            info_ff <= nxt_info;
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
        end
    end

    // outputs straight from the registers
    assign busy = busy_ff;
    assign done = done_ff;
    assign access_error = acc_ff;
    assign protect_error = prot_ff;
    assign array_we = we_ff;
    assign array_info = info_ff;
    assign array_addr = addr_ff;
    assign array_wdata = wdata_ff;
endmodule

// ==== test/flash_seq_monitor.sv ====
// assertion checker for the longword sequencer ports
`timescale 1ns/10ps
module flash_seq_monitor #(
    parameter int PROG_CYCLES = flash_seq_pkg::PROG_CYCLES
) (
    // clock, reset, command
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic launch,
    input wire logic [7:0] flash_command_code,
    input wire logic [flash_seq_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [31:0] cmd_data,
    input wire logic [31:0] protect_mask,
    input wire logic fetch_active,
    input wire logic clear_errors,
    // status and array port
    input wire logic busy,
    input wire logic done,
    input wire logic access_error,
    input wire logic protect_error,
    input wire logic array_we,
    input wire logic array_info,
    input wire logic [flash_seq_pkg::ADDR_W-1:0] array_addr,
    input wire logic [31:0] array_wdata
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire logic [7:0] c = flash_command_code;
    wire logic go = launch && !busy;
    wire logic prot = protect_mask[cmd_addr[17:13]];
    wire logic pe = (c == 8'h06 || c == 8'h09);
    sequence s_run; busy ##PROG_CYCLES (array_we && busy); endsequence
    sequence s_end; done && !busy; endsequence
    property p_prog; go && c == 8'h06 && !fetch_active && !prot
        |=> s_run ##1 s_end; endproperty
    a_prog: assert property (p_prog) else $error("program timing");
    property p_gone; go && (c == 8'h0B || c == 8'h46)
        |=> access_error && !busy; endproperty
    a_gone: assert property (p_gone) else $error("removed code");
    property p_prot; go && pe && !fetch_active && prot
        |=> protect_error && !busy; endproperty
    a_prot: assert property (p_prot) else $error("protection");
    property p_once; go && c == 8'h43 && !fetch_active
        && cmd_addr[7:0] < 8'hC0 |=> access_error && !busy; endproperty
    a_once: assert property (p_once) else $error("reserved info");
    property p_fetch; go && fetch_active && pe
        |=> access_error && !busy ##1 !array_we; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch write");
    property p_align; array_we |-> array_addr[1:0] == 2'h0
        && (!array_info || array_addr[7:0] >= 8'hC0); endproperty
    a_align: assert property (p_align) else $error("addr");
    property p_bad; go && !(c inside {8'h06, 8'h43, 8'h09})
        |=> (access_error && !array_we)[*3]; endproperty
    a_bad: assert property (p_bad) else $error("bad code");
    property p_clr; clear_errors && !launch
        |=> !access_error && !protect_error; endproperty
    a_clr: assert property (p_clr) else $error("clear");
endmodule
bind flash_longword_sequencer flash_seq_monitor #(
    .PROG_CYCLES(PROG_CYCLES)
) mon (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .launch(launch),
    .flash_command_code(flash_command_code),
    .cmd_addr(cmd_addr),
    .cmd_data(cmd_data),
    .protect_mask(protect_mask),
    .fetch_active(fetch_active),
    .clear_errors(clear_errors),
    .busy(busy),
    .done(done),
    .access_error(access_error),
    .protect_error(protect_error),
    .array_we(array_we),
    .array_info(array_info),
    .array_addr(array_addr),
    .array_wdata(array_wdata)
);

// ==== test/tb_flash_longword_sequencer.sv ====
// self-checking bench for the longword sequencer
`timescale 1ns/10ps
module tb_flash_longword_sequencer;
    localparam int PROG = 2;
    logic sys_clk = 1'h0, rst_n = 1'h0, launch = 1'h0;
    logic fetch_active = 1'h0, clear_errors = 1'h0;
    logic busy, done, access_error, protect_error;
    logic array_we, array_info, seen, got_info, busy_1;
    logic [7:0] flash_command_code = 8'h00;
    logic [17:0] cmd_addr = 18'h0, array_addr, got_addr;
    logic [31:0] cmd_data = 32'h0, protect_mask = 32'h0;
    logic [31:0] array_wdata, got_data;
    int err_total = 0, cmp_count = 0, we_at, done_at;
    always #12.5 sys_clk = ~sys_clk;
    flash_longword_sequencer #(
        .PROG_CYCLES(PROG)
    ) dut (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .launch(launch),
        .flash_command_code(flash_command_code),
        .cmd_addr(cmd_addr),
        .cmd_data(cmd_data),
        .protect_mask(protect_mask),
        .fetch_active(fetch_active),
        .clear_errors(clear_errors),
        .busy(busy),
        .done(done),
        .access_error(access_error),
        .protect_error(protect_error),
        .array_we(array_we),
        .array_info(array_info),
        .array_addr(array_addr),
        .array_wdata(array_wdata)
    );
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic op(logic [7:0] c, logic [17:0] a, logic f);
        @(negedge sys_clk);
        flash_command_code = c;
        cmd_addr = a;
        fetch_active = f;
        launch = 1'h1;
        @(negedge sys_clk);
        launch = 1'h0;
        seen = 1'h0;
        busy_1 = busy;
        we_at = -1;
        done_at = -1;
        for (int i = 0; i < 5; i++) begin
            if (array_we === 1'b1) begin
                seen = 1'h1;
                we_at = i;
                got_addr = array_addr;
                got_data = array_wdata;
                got_info = array_info;
            end
            if (done === 1'b1) begin
                done_at = i;
            end
            @(negedge sys_clk);
        end
        fetch_active = 1'h0;
    endtask
    task automatic clr;
        clear_errors = 1'h1;
        @(negedge sys_clk);
        clear_errors = 1'h0;
    endtask
    task automatic t_prog;
        cmd_data = 32'hA5C3_0F12;
        op(8'h06, 18'h2_1237, 1'b0);
        chk("we", 32'h1, 32'(seen));
        chk("addr", 32'h2_1234, 32'(got_addr));
        chk("data", 32'hA5C3_0F12, got_data);
        chk("busy", 32'h1, 32'(busy_1));
        chk("we_at", 32'(PROG), 32'(we_at));
        chk("done_at", 32'(PROG + 1), 32'(done_at));
        chk("idle", 32'h0, 32'(busy | done));
    endtask
    task automatic t_prot;
        protect_mask = 32'h0000_0008;
        op(8'h09, 18'h0_6000, 1'b0);
        chk("prot", 32'h1, 32'(protect_error & ~seen));
        clr();
        chk("clear", 32'h0, 32'(protect_error));
        op(8'h09, 18'h0_8000, 1'b0);
        chk("erase", 32'hFFFF_FFFF, got_data);
        protect_mask = 32'h0;
    endtask
    task automatic t_once;
        op(8'h43, 18'h0_00C4, 1'b0);
        chk("info", 32'h1C4, 32'({got_info, got_addr[7:0]}));
        op(8'h43, 18'h0_00BC, 1'b0);
        chk("resv", 32'h1, 32'(access_error));
        clr();
        op(8'h06, 18'h0_0100, 1'b1);
        chk("fetch", 32'h1, 32'(access_error & ~seen));
        clr();
    endtask
    task automatic t_bad;
        logic [7:0] codes [5] = '{8'h0B, 8'h46, 8'h07, 8'h08, 8'h44};
        foreach (codes[i]) begin
            op(codes[i], 18'h0_0200, 1'b0);
            chk("code", 32'h1, 32'(access_error & ~seen));
            chk("busy", 32'h0, 32'(busy_1));
            chk("done", 32'hFFFF_FFFF, 32'(done_at));
            clr();
        end
    endtask
    task automatic t_reset;
        op(8'h46, 18'h0_0300, 1'b0);
        rst_n = 1'h0;
        @(negedge sys_clk);
        chk("rst", 32'h0, 32'({busy, access_error, array_we}));
        rst_n = 1'h1;
        op(8'h06, 18'h0_0404, 1'b0);
        chk("again", 32'h1, 32'(seen));
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge sys_clk);
        rst_n = 1'h1;
        t_prog();
        t_prot();
        t_once();
        t_bad();
        t_reset();
        stop_test();
    end
    initial begin
        #20000;
        err_total++;
        stop_test();
    end
endmodule
